// File: pkg/adccal_pkg.sv
// Purpose: Shared constants, types and helpers of the ADC offset and gain calibration stage.
// Assumes: One clock; raw codes arrive as one-cycle strobes from the decimation filter.
// Notes:   Overview of operation follows.
// Overview of operation
// RULE_01: Output equals raw plus offset, times gain.
// RULE_02: Disabled correction is skipped, register ignored.
// RULE_03: Overload judged on final result only.
// RULE_04: Intermediates carry headroom bits without loss.
// RULE_05: Out-of-range sum recovered by gain: no clamp.
// RULE_06: Offset register: 24-bit signed at 0x9.
// RULE_07: Offset low byte forced to zero.
// RULE_08: Offset adder is 16-bit, no delay.
// RULE_09: Offset enable affects next result only.
// RULE_10: New offset value affects next result only.
// RULE_11: Gain at 0xA, result at 0x0.
// RULE_12: Both enables in third configuration register.
// RULE_13: Gain is upper 16 bits over 32768.
// RULE_14: Gain multiply adds 15 clocks of latency.
// RULE_15: Gain write or enable affects next result.
// RULE_16: Out-of-range result clamped and overload flagged.
package adccal_pkg;

  // Register bus geometry and register offsets.
  localparam int           REG_AW        = 4;
  localparam int           REG_DW        = 24;
  localparam logic [3:0]   ADDR_RESULT   = 4'h0;
  localparam logic [3:0]   ADDR_STATUS   = 4'h1;
  localparam logic [3:0]   ADDR_THIRD_CONFIGURATION_REGISTER  = 4'h3;
  localparam logic [3:0]   ADDR_OFFSET   = 4'h9;
  localparam logic [3:0]   ADDR_GAIN     = 4'hA;

  // Field positions.
  localparam int           CFG_GAIN_EN   = 0;
  localparam int           CFG_OFF_EN    = 1;
  localparam int           STS_OVL       = 0;
  localparam int           STS_BUSY      = 1;
  localparam int           STS_OVR       = 2;
  localparam int           CAL_LSB       = 8;

  // Datapath widths: raw code, headroom sum, gain code, product, scaled result.
  localparam int           RAW_W         = 16;
  localparam int           SUM_W         = 17;
  localparam int           GCODE_W       = 16;
  localparam int           PROD_W        = 33;
  localparam int           OUT_W         = 18;
  localparam int           GAIN_FRAC     = 15;

  // Latency of the gain path in clocks, and the serial steps after the first.
  localparam int           GAIN_LAT_CYC  = 15;
  localparam logic [3:0]   MUL_STEPS     = 4'(GAIN_LAT_CYC - 1);

  // Values after reset.
  localparam logic [23:0]  OFFSET_RST    = 24'h000000;
  localparam logic [23:0]  GAIN_RST      = 24'h000000;
  localparam logic [1:0]   CFG_RST       = 2'h0;
  localparam logic [15:0]  RESULT_RST    = 16'h0000;

  // Full-scale codes of the signed output.
  localparam logic [15:0]  FS_POS        = 16'h7FFF;
  localparam logic [15:0]  FS_NEG        = 16'h8000;

  typedef enum logic {MUL_IDLE, MUL_RUN} adccal_mul_state_e;

  // Clamp a wide signed value to 16 bits; returns {overload, code}.
  function automatic logic [16:0] adccal_sat(input logic signed [OUT_W-1:0] v);
    logic [16:0] r;
    r = {1'b0, v[15:0]};
    if (v > $signed(18'sh07FFF)) begin
      r = {1'b1, FS_POS};
    end else if (v < $signed(-18'sh08000)) begin
      r = {1'b1, FS_NEG};
    end
    return r;
  endfunction

endpackage

// File: pkg/adccal_mul_if.sv
// Purpose: Connection between the calibration control and the serial gain multiplier.
// Assumes: Single clock domain shared by both ends.
// Notes:   The product is valid while done is high and until the next start.
`timescale 1ns/100ps
`default_nettype none
interface adccal_mul_if;
  import adccal_pkg::*;
  logic                      start;
  logic signed [SUM_W-1:0]   mcand;
  logic [GCODE_W-1:0]        mplier;
  logic                      done;
  logic                      busy;
  logic signed [OUT_W-1:0]   product;

  modport ctrl (output start, output mcand, output mplier,
                input done, input busy, input product);
  modport mul  (input start, input mcand, input mplier,
                output done, output busy, output product);
endinterface
`default_nettype wire

// File: hw/adccal_gain_mul.sv
// Purpose: Add-and-shift multiplier of the offset-corrected code by the gain code.
// Assumes: start is a one-cycle pulse and is not raised while busy is high.
// Notes:   Two gain bits are folded into the first edge so done lands on the latency.
`timescale 1ns/100ps
`default_nettype none
module adccal_gain_mul (
  // Clock and reset.
  input  wire logic      clk_i,
  input  wire logic      resetn_i,
  // Operands and product.
  adccal_mul_if.mul      mi
);
  import adccal_pkg::*;

  adccal_mul_state_e          state;
  logic [3:0]                 cnt;
  logic signed [PROD_W-1:0]   acc;
  logic signed [PROD_W-1:0]   a_ext;
  logic [GCODE_W-1:0]         b_q;
  logic signed [PROD_W-1:0]   next_acc;
  logic signed [PROD_W-1:0]   init_acc;
  logic signed [PROD_W-1:0]   in_ext;
  logic                       done;

  // Sign-extend the incoming multiplicand to product width.
  assign in_ext = PROD_W'(mi.mcand);

  // First edge takes gain bits 15 and 14 at once.
  always_comb begin
    init_acc = '0;
    if (mi.mplier[GCODE_W-1]) begin
      init_acc = in_ext <<< 1;
    end
    if (mi.mplier[GCODE_W-2]) begin
      init_acc = init_acc + in_ext;
    end
  end

  // Each later step doubles the partial product and adds the next bit.
  always_comb begin
    next_acc = acc <<< 1;
    if (b_q[cnt - 4'h1]) begin
      next_acc = next_acc + a_ext;
    end
  end

  // Sequencer.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= MUL_IDLE;
      cnt   <= 4'h0;
    end else begin
      case (state)
        MUL_IDLE: begin
          if (mi.start) begin
            state <= MUL_RUN;
            cnt   <= MUL_STEPS;
          end
        end
        MUL_RUN: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            state <= MUL_IDLE;
          end
        end
        default: state <= MUL_IDLE;
      endcase
    end
  end

  // Operand capture and accumulation; the full-width product never clips.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc   <= '0;
      a_ext <= '0;
      b_q   <= '0;
    end else if (state == MUL_IDLE && mi.start) begin
      acc   <= init_acc; // RULE_04
      a_ext <= in_ext;
      b_q   <= mi.mplier;
    end else if (state == MUL_RUN) begin
      acc   <= next_acc;
    end
  end

  // Done rises with the last step.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done <= 1'b0;
    end else begin
      done <= (state == MUL_RUN) && (cnt == 4'h1); // RULE_14
    end
  end

  // Dividing by 32768 is a drop of the fraction bits.
  assign mi.product = acc[PROD_W-1:GAIN_FRAC]; // RULE_13
  assign mi.done    = done;
  assign mi.busy    = (state == MUL_RUN);

endmodule
`default_nettype wire

// File: hw/adccal_top.sv
// Purpose: Offset and gain calibration of raw conversion codes, with its registers.
// Assumes: Raw codes are one-cycle strobes spaced wider than the gain latency.
// Notes:   A code that arrives while the gain path is busy is dropped and flagged.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module adccal_top #(
  parameter int RAW_BITS = 16,
  parameter int REG_BITS = 24
) (
  // Clock and reset.
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  // Raw conversion stream from the decimation filter.
  input  wire logic                          raw_valid_i,
  input  wire logic [15:0]                   raw_code_i,
  // Register port.
  input  wire logic [adccal_pkg::REG_AW-1:0] reg_addr_i,
  input  wire logic [adccal_pkg::REG_DW-1:0] reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output var  logic [adccal_pkg::REG_DW-1:0] reg_rdata_o,
  // Calibrated result stream.
  output var  logic                          data_ready_o,
  output var  logic [15:0]                   result_o,
  output var  logic                          overload_o
);
  import adccal_pkg::*;

  // The datapath is built for these widths only.
  if (RAW_BITS != RAW_W || REG_BITS != REG_DW) begin : g_width_check
    $error("adccal_top supports only 16-bit codes and 24-bit registers.");
  end

  // Software-visible state.
  logic [23:0]                offset_correction;
  logic [23:0]                gain_correction;
  logic                       offset_correction_enable;
  logic                       gain_correction_enable;
  logic                       overrun;

  // Datapath state.
  logic signed [SUM_W-1:0]    offset_sum;
  logic signed [RAW_W-1:0]    offset_hi;
  logic [GCODE_W-1:0]         gain_hi;
  logic                       accept;
  logic                       launch_gain;
  logic                       direct_take;
  logic signed [OUT_W-1:0]    direct_val;
  logic [16:0]                direct_sat;
  logic [16:0]                gain_sat;
  logic [REG_DW-1:0]          next_rdata;
  logic                       wr_offset;
  logic                       wr_gain;
  logic                       wr_cfg;
  logic                       rd_status;

  adccal_mul_if mi ();

  // Register write decode; one strobe at a time from the master.
  always_comb begin
    wr_offset = 1'b0;
    wr_gain   = 1'b0;
    wr_cfg    = 1'b0;
    if (!reg_wr_i) begin
      wr_offset = 1'b0;
    end else if (reg_addr_i == ADDR_OFFSET) begin
      wr_offset = 1'b1; // RULE_06
    end else if (reg_addr_i == ADDR_GAIN) begin
      wr_gain = 1'b1; // RULE_11
    end else if (reg_addr_i == ADDR_THIRD_CONFIGURATION_REGISTER) begin
      wr_cfg = 1'b1; // RULE_12
    end
  end

  assign rd_status = reg_rd_i && (reg_addr_i == ADDR_STATUS);

  // Offset register; the full 24 bits are stored and read back.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      offset_correction <= OFFSET_RST;
    end else if (wr_offset) begin
      offset_correction <= reg_wdata_i; // RULE_06
    end
  end

  // Gain register; only the upper two bytes ever reach the multiplier.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gain_correction <= GAIN_RST;
    end else if (wr_gain) begin
      gain_correction <= reg_wdata_i; // RULE_11
    end
  end

  // The two enables are written together but act independently.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      offset_correction_enable <= CFG_RST[CFG_OFF_EN];
      gain_correction_enable   <= CFG_RST[CFG_GAIN_EN];
    end else if (wr_cfg) begin
      offset_correction_enable <= reg_wdata_i[CFG_OFF_EN]; // RULE_12
      gain_correction_enable   <= reg_wdata_i[CFG_GAIN_EN]; // RULE_12
    end
  end

  // Read mux; reserved bits and unmapped offsets read as zero.
  always_comb begin
    next_rdata = '0;
    if (reg_addr_i == ADDR_RESULT) begin
      next_rdata = {8'h00, result_o}; // RULE_11
    end else if (reg_addr_i == ADDR_STATUS) begin
      next_rdata[STS_OVL]  = overload_o;
      next_rdata[STS_BUSY] = mi.busy;
      next_rdata[STS_OVR]  = overrun;
    end else if (reg_addr_i == ADDR_THIRD_CONFIGURATION_REGISTER) begin
      next_rdata[CFG_OFF_EN]  = offset_correction_enable;
      next_rdata[CFG_GAIN_EN] = gain_correction_enable;
    end else if (reg_addr_i == ADDR_OFFSET) begin
      next_rdata = offset_correction;
    end else if (reg_addr_i == ADDR_GAIN) begin
      next_rdata = gain_correction;
    end
  end

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // Low bytes of both calibration registers are treated as zero.
  assign offset_hi = offset_correction[REG_DW-1:CAL_LSB]; // RULE_07
  assign gain_hi   = gain_correction[REG_DW-1:CAL_LSB]; // RULE_13

  // Combinational signed add with one spare bit, so the raw code and
  // its correction land in the same cycle without any clipping here.
  always_comb begin
    offset_sum = SUM_W'(signed'(raw_code_i));
    if (offset_correction_enable) begin
      offset_sum = SUM_W'(signed'(raw_code_i)) + SUM_W'(offset_hi); // RULE_08
    end
  end

  // A code is taken unless the gain path is still busy with the last one.
  assign accept      = raw_valid_i && !mi.busy;
  assign launch_gain = accept && gain_correction_enable; // RULE_01
  assign direct_take = accept && !gain_correction_enable; // RULE_02

  // The multiplier snapshots its operands at launch, so later register
  // writes cannot disturb a conversion already in flight.
  assign mi.start  = launch_gain; // RULE_15
  assign mi.mcand  = offset_sum; // RULE_01
  assign mi.mplier = gain_hi;

  adccal_gain_mul u_gain_mul (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .mi       (mi)
  );

  // Bypass path: the sum is judged only once, as the final value.
  assign direct_val = OUT_W'(offset_sum);
  assign direct_sat = adccal_sat(direct_val); // RULE_16
  // Gain path: the intermediate sum is never judged, only the product.
  assign gain_sat   = adccal_sat(mi.product); // RULE_03 RULE_05

  // The held result changes only with a new data-ready event, never on
  // a register or enable write.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_o   <= RESULT_RST;
      overload_o <= 1'b0;
    end else if (mi.done) begin
      result_o   <= gain_sat[15:0]; // RULE_16
      overload_o <= gain_sat[16]; // RULE_03
    end else if (direct_take) begin
      result_o   <= direct_sat[15:0]; // RULE_09 RULE_10
      overload_o <= direct_sat[16]; // RULE_03
    end
  end

  // Data ready pulses with each new result; the gain path arrives later
  // by its latency, and if both paths finish in one cycle the gain result wins and the bypass code is lost.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_ready_o <= 1'b0;
    end else begin
      data_ready_o <= mi.done || direct_take; // RULE_14
    end
  end

  // Dropped codes are sticky; a status read clears it, but a new drop
  // in the same cycle wins so that no event goes unseen.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overrun <= 1'b0;
    end else if (raw_valid_i && !accept) begin
      overrun <= 1'b1;
    end else if (rd_status) begin
      overrun <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: test/adccal_checker.sv
// Purpose: Port-level timing and value checks of the calibration stage.
// Assumes: One clock; config and busy window are mirrored from port traffic.
// Notes:   Bound to adccal_top after the module.
`timescale 1ns/100ps
`default_nettype none
module adccal_checker (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        resetn_i,
  // Watched ports.
  input wire logic        raw_valid_i,
  input wire logic [15:0] raw_code_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [23:0] reg_rdata_o,
  input wire logic        data_ready_o,
  input wire logic [15:0] result_o,
  input wire logic        overload_o
);
  logic [1:0] cfg;
  logic [3:0] busy_cnt;
  logic       acc;
  // A code is taken only outside the gain busy window.
  assign acc = raw_valid_i && (busy_cnt == 4'h0);
  // Mirror of config and busy window; the checker cannot see inside the block.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg      <= 2'h0;
      busy_cnt <= 4'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == 4'h3) cfg <= reg_wdata_i[1:0];
      if (acc && cfg[0]) busy_cnt <= 4'hE;
      else if (busy_cnt != 4'h0) busy_cnt <= busy_cnt - 4'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_gain_latency: assert property (acc && cfg[0] |-> ##16 data_ready_o)
    else $error("gain result not ready 16 cycles after its code");
  a_bypass_next: assert property (acc && !cfg[0] |=> data_ready_o)
    else $error("result without gain not ready next cycle");
  a_plain_pass: assert property (acc && cfg == 2'h0 |=> result_o == $past(raw_code_i) && !overload_o)
    else $error("uncorrected code altered");
  a_result_held: assert property (!data_ready_o |-> $stable(result_o) && $stable(overload_o))
    else $error("result changed without data ready");
  a_clamp_code: assert property (overload_o |-> result_o == 16'h7FFF || result_o == 16'h8000)
    else $error("overload without full-scale code");
  a_ready_cause: assert property (data_ready_o |-> $past(acc && !cfg[0]) || $past(acc && cfg[0], 16))
    else $error("data ready without a matching code");
  a_read_result: assert property (reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o == {8'h00, $past(result_o)})
    else $error("result register read wrong");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 24'h000000)
    else $error("read data outside its cycle");
  c_both_on: cover property (acc && cfg == 2'h3);
  c_clamped: cover property (data_ready_o && overload_o);
  c_read_offset: cover property (reg_rd_i && reg_addr_i == 4'h9);
endmodule
bind adccal_top adccal_checker u_chk (.clk_i, .resetn_i, .raw_valid_i, .raw_code_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .data_ready_o, .result_o, .overload_o);
`default_nettype wire

// File: test/adccal_decim_model.sv
// Purpose: Stand-in for the decimation filter that hands raw codes over.
// Assumes: Codes leave as one-cycle strobes launched after a rising edge.
// Notes:   Between strobes the code lines carry the inverse of the last code.
`timescale 1ns/100ps
`default_nettype none
module adccal_decim_model (
  // Clock.
  input  wire logic        clk_i,
  // Raw stream.
  output var  logic        raw_valid_o,
  output var  logic [15:0] raw_code_o
);
  initial begin
    raw_valid_o = 1'b0;
    raw_code_o  = 16'h0000;
  end
  // One strobe; the code is not held after it, so stale data cannot pass.
  task automatic send(input logic [15:0] code);
    @(posedge clk_i);
    raw_valid_o <= 1'b1;
    raw_code_o  <= code;
    @(posedge clk_i);
    raw_valid_o <= 1'b0;
    raw_code_o  <= ~code;
  endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Purpose: Self-checking bench of the offset and gain calibration stage.
// Assumes: Register port and raw stream follow the hand-over timing.
// Notes:   Expected codes come from a local model of add, scale and clamp.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import adccal_pkg::*;
  logic        clk_i;
  logic        resetn_i;
  logic        raw_valid;
  logic [15:0] raw_code;
  logic [3:0]  addr;
  logic [23:0] wdata;
  logic [23:0] rdata;
  logic        wr;
  logic        rd;
  logic        ready;
  logic        ovl;
  logic [15:0] res;
  logic [23:0] off_r;
  logic [23:0] gain_r;
  logic [1:0]  cfg_r;
  int          bad_count;
  int          checks;
  adccal_decim_model dec (.clk_i, .raw_valid_o(raw_valid), .raw_code_o(raw_code));
  adccal_top dut (.clk_i, .resetn_i, .raw_valid_i(raw_valid), .raw_code_i(raw_code),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .data_ready_o(ready), .result_o(res), .overload_o(ovl));
  // Free-running 100 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_i);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [23:0] d);
    @(posedge clk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Wide intermediate keeps out-of-range sums; only the end result is clamped.
  function automatic logic [16:0] model(input logic [15:0] raw);
    logic signed [35:0] y;
    y = $signed({{2{raw[15]}}, raw});
    if (cfg_r[1]) y = y + $signed({{2{off_r[23]}}, off_r[23:8]});
    if (cfg_r[0]) y = (y * $signed({2'b00, gain_r[23:8]})) >>> 15;
    if (y > 32767) return {1'b1, 16'h7FFF};
    if (y < -32768) return {1'b1, 16'h8000};
    return {1'b0, y[15:0]};
  endfunction
  // New settings must leave the held result alone.
  task automatic setup(input logic [23:0] o, input logic [23:0] g, input logic [1:0] c);
    logic [16:0] held;
    logic [23:0] v;
    held = {ovl, res};
    off_r = o;
    gain_r = g;
    cfg_r = c;
    wr_reg(ADDR_OFFSET, o);
    wr_reg(ADDR_GAIN, g);
    wr_reg(ADDR_THIRD_CONFIGURATION_REGISTER, {22'h0, c});
    chk({ovl, res}, held);
    rd_reg(ADDR_THIRD_CONFIGURATION_REGISTER, v);
    chk(v, {22'h0, c});
  endtask
  task automatic conv(input logic [15:0] code);
    int          n;
    logic [16:0] e;
    e = model(code);
    n = 0;
    dec.send(code);
    // Sampling mid-cycle sees the one-cycle ready pulse while it stands.
    do begin
      @(negedge clk_i);
      n++;
    end while (ready !== 1'b1 && n < 40);
    chk(24'(n), cfg_r[0] ? 24'h10 : 24'h1);
    chk({ovl, res}, e);
  endtask
  task automatic t_regs();
    logic [23:0] v;
    chk({ovl, res}, 24'h0);
    rd_reg(ADDR_OFFSET, v);
    chk(v, 24'h0);
    rd_reg(4'h5, v);
    chk(v, 24'h0);
    wr_reg(ADDR_RESULT, 24'h00ABCD);
    rd_reg(ADDR_RESULT, v);
    chk(v, 24'h0);
    wr_reg(ADDR_OFFSET, 24'hA5C3E1);
    rd_reg(ADDR_OFFSET, v);
    chk(v, 24'hA5C3E1);
    $display("test regs done");
  endtask
  task automatic t_bypass();
    setup(24'h7F00AA, 24'h4000FF, 2'h0);
    conv(16'h1234);
    conv(16'h8001);
    $display("test bypass done");
  endtask
  task automatic t_offset();
    setup(24'hFFFF55, 24'h0, 2'h2);
    conv(16'h0000);
    conv(16'h8000);
    setup(24'h000133, 24'h0, 2'h2);
    conv(16'h7FFF);
    $display("test offset done");
  endtask
  task automatic t_gain();
    setup(24'h7FFF00, 24'h400012, 2'h3);
    conv(16'h7FFF);
    setup(24'h800000, 24'h4000AB, 2'h3);
    conv(16'h8000);
    setup(24'h0, 24'hFFFF00, 2'h1);
    conv(16'h7000);
    conv(16'hFFFD);
    setup(24'h0, 24'h800000, 2'h1);
    conv(16'h8123);
    $display("test gain done");
  endtask
  // A code inside the gain latency is dropped, flagged and gives no result.
  task automatic t_overrun();
    int          n;
    int          extra;
    logic [23:0] v;
    setup(24'h0, 24'h800000, 2'h1);
    dec.send(16'h0100);
    dec.send(16'h0200);
    rd_reg(ADDR_STATUS, v);
    chk(v, 24'h000006);
    rd_reg(ADDR_STATUS, v);
    chk(v, 24'h000002);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ready !== 1'b1 && n < 40);
    chk({ovl, res}, 24'h000100);
    extra = 0;
    repeat (20) begin
      @(negedge clk_i);
      if (ready === 1'b1) begin
        extra++;
      end
    end
    chk(24'(extra), 24'h0);
    rd_reg(ADDR_STATUS, v);
    chk(v, 24'h000000);
    $display("test overrun done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Reset for eight cycles, then the scenarios in order.
  initial begin
    resetn_i = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 24'h0;
    off_r = 24'h0;
    gain_r = 24'h0;
    cfg_r = 2'h0;
    bad_count = 0;
    checks = 0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_bypass();
    t_offset();
    t_gain();
    t_overrun();
    close_out();
  end
  // The scenarios need well under 1000 cycles; a hang stops here.
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
